// *** core/urx_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the serial receive block
`ifndef URX_CONSTS_SVH
`define URX_CONSTS_SVH
`define URX_ADDR_CTRL 4'h0
`define URX_ADDR_STATUS 4'h1
`define URX_ADDR_RXBUF 4'h2
`define URX_ADDR_TXBUF 4'h3
`define URX_CTRL_RX_ENABLE 0
`define URX_CTRL_TX_ENABLE 1
`define URX_CTRL_PARITY_ENABLE 2
`define URX_CTRL_PARITY_EVEN 3
`define URX_CTRL_TX_STOP_LEN 4
`define URX_CTRL_RX_STOP_LEN 5
`define URX_CTRL_RATE_LSB 6
`define URX_CTRL_RESET 8'h00
`define URX_ST_PARITY 7
`define URX_ST_FRAMING 6
`define URX_ST_OVERRUN 5
`define URX_ST_FULL 4
`define URX_ST_TX_DONE 3
`define URX_ST_TX_EMPTY 2
`define URX_RT_PER_BIT 16
`define URX_RT_S1 4'h7
`define URX_RT_S2 4'h8
`define URX_RT_S3 4'h9
`define URX_RT_LAST 4'hF
`define URX_DIV_RATE0 8'h0D
`define URX_DIV_RATE1 8'h1A
`define URX_DIV_RATE2 8'h34
`define URX_DIV_RATE3 8'h68
`define URX_FIFO_DEPTH 16
`endif

// *** core/urx_fifo.sv ***
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module urx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // Count is one bit wider than the index so that full and empty differ
   assign in_ready = (cnt_q < (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];
   always_ff @(posedge clk) begin
      if (srst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule

// *** core/urx_pkg.sv ***
// Types shared by the serial receive block
package urx_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } urx_bus_t;
   typedef struct packed {
      logic parity;
      logic framing;
      logic overrun;
      logic full;
   } urx_flags_t;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } urx_state_t;
endpackage

// *** core/urx_receiver.sv ***
// Serial receive path, receive buffer and status flags of the asynchronous port
//
// Operation
// - With receive enabled, frames on the serial input are shifted in and buffered.
// - After stop bits, data bits alone load the buffer, set full, pulse interrupt.
// - Receive bit timing comes from the shared rate-select field.
// - On overrun the new character is dropped; the buffer is unchanged.
// - Clearing receive enable acts after the current frame; framing error may defeat it.
// - Parity error flag sets when computed parity differs from received parity bit.
// - Framing error flag sets when a stop bit samples as 0.
// - Overrun flag sets when a whole further character arrives before buffer read.
// - Parity, framing, overrun and full clear on buffer read after status read.
// - While overrun stays set, reception is disabled.
// - Overrun set between status read and buffer read survives that buffer read.
// - Full flag sets when a character is loaded into the buffer.
// - Transmit-empty sets when sending starts; cleared by buffer write after status read.
// - Transmit-done sets when sending ends with buffer empty; clears when sending restarts.
// - Each bit is sampled at subclocks 7, 8 and 9 and decided by majority.
// - Frame is start, eight data, optional parity, one or two stop bits.
`timescale 1ns/1ps
`include "urx_consts.svh"
module urx_receiver (
   input wire logic clk,
   input wire logic srst,
   input wire urx_pkg::urx_bus_t bus,
   output logic [7:0] rdata,
   input wire logic rx_pin,
   input wire logic rt_ext_tick,
   input wire logic tx_start,
   input wire logic tx_end,
   output logic rx_irq,
   output logic [7:0] rx_data,
   output logic rx_data_valid,
   input wire logic rx_data_ready
);
   import urx_pkg::*;

   // ----------------------------------------------------------------
   // Control register and bus decode
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] rdata_q;
   logic [7:0] rx_buffer_q;
   logic [7:0] tx_buffer_q;
   urx_flags_t flag_q;
   urx_flags_t armed_q;
   logic tx_empty_flag_q;
   logic tx_done_flag_q;
   logic tx_armed_q;
   logic tx_pending_q;
   logic rx_irq_q;
   logic rx_en_active_q;

   wire wr_ctrl = bus.wr && (bus.addr == `URX_ADDR_CTRL);
   wire wr_tx = bus.wr && (bus.addr == `URX_ADDR_TXBUF);
   wire rd_status = bus.rd && (bus.addr == `URX_ADDR_STATUS);
   wire rd_rxbuf = bus.rd && (bus.addr == `URX_ADDR_RXBUF);
   wire rx_enable = ctrl_q[`URX_CTRL_RX_ENABLE];
   wire parity_enable = ctrl_q[`URX_CTRL_PARITY_ENABLE];
   wire parity_even = ctrl_q[`URX_CTRL_PARITY_EVEN];
   wire rx_stop_two = ctrl_q[`URX_CTRL_RX_STOP_LEN];
   wire [1:0] rate_select = ctrl_q[`URX_CTRL_RATE_LSB +: 2];
   wire [7:0] status_word = {flag_q.parity, flag_q.framing, flag_q.overrun, flag_q.full,
                             tx_done_flag_q, tx_empty_flag_q, 2'b00};
   wire [7:0] rd_mux = (bus.addr == `URX_ADDR_CTRL) ? ctrl_q :
                       (bus.addr == `URX_ADDR_STATUS) ? status_word :
                       (bus.addr == `URX_ADDR_RXBUF) ? rx_buffer_q :
                       (bus.addr == `URX_ADDR_TXBUF) ? tx_buffer_q : 8'h00;

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q <= `URX_CTRL_RESET;
         rdata_q <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= bus.wdata;
         end
         rdata_q <= bus.rd ? rd_mux : 8'h00;
      end
   end
   assign rdata = rdata_q;

   // ----------------------------------------------------------------
   // Subclock divider: sixteen ticks per bit
   // ----------------------------------------------------------------
   // Rates as divisions of clk; code 3 takes an outside timer tick
   function automatic logic [7:0] rate_div(input logic [1:0] sel);
      unique case (sel)
         2'b00: rate_div = `URX_DIV_RATE0;
         2'b01: rate_div = `URX_DIV_RATE1;
         2'b10: rate_div = `URX_DIV_RATE2;
         default: rate_div = `URX_DIV_RATE3;
      endcase
   endfunction
   logic [7:0] div_q;
   logic rt_tick_q;
   wire div_end = (div_q >= rate_div(rate_select) - 8'h01);
   always_ff @(posedge clk) begin
      if (srst) begin
         div_q <= 8'h00;
         rt_tick_q <= 1'b0;
      end else begin
         div_q <= div_end ? 8'h00 : div_q + 8'h01;
         rt_tick_q <= (rate_select == 2'b11) ? rt_ext_tick : div_end;
      end
   end

   // ----------------------------------------------------------------
   // Receive engine
   // ----------------------------------------------------------------
   urx_state_t state_q;
   logic [3:0] rt_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q;
   logic [2:0] vote_q;
   logic par_bit_q;
   logic framing_err_flag_q;
   logic frame_done_q;
   logic frame_par_q;

   wire majority = (vote_q[0] & vote_q[1]) | (vote_q[1] & rx_pin) | (vote_q[0] & rx_pin);
   wire bit_decide = rt_tick_q && (rt_q == `URX_RT_S3);
   wire bit_end = rt_tick_q && (rt_q == `URX_RT_LAST);
   wire [3:0] data_bits = parity_enable ? 4'h9 : 4'h8;
   wire [3:0] stop_bits = rx_stop_two ? 4'h2 : 4'h1;
   wire can_start = rx_en_active_q && !flag_q.overrun;

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= RX_IDLE;
         rt_q <= 4'h0;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         vote_q <= 3'b000;
         par_bit_q <= 1'b0;
         framing_err_flag_q <= 1'b0;
         frame_done_q <= 1'b0;
         frame_par_q <= 1'b0;
         rx_en_active_q <= 1'b0;
      end else begin
         frame_done_q <= 1'b0;
         // Enable only sampled between frames; framing error lets old enable linger
         if (state_q == RX_IDLE && !framing_err_flag_q) begin
            rx_en_active_q <= rx_enable;
         end else if (state_q == RX_IDLE && rx_enable) begin
            rx_en_active_q <= 1'b1;
         end
         if (rt_tick_q) begin
            rt_q <= rt_q + 4'h1;
            if (rt_q == `URX_RT_S1) vote_q[0] <= rx_pin;
            if (rt_q == `URX_RT_S2) vote_q[1] <= rx_pin;
         end
         unique case (state_q)
            RX_IDLE: begin
               rt_q <= 4'h0;
               if (rt_tick_q && can_start && !rx_pin) begin
                  state_q <= RX_START;
                  framing_err_flag_q <= 1'b0;
                  rt_q <= 4'h1;
               end
            end
            RX_START: begin
               if (bit_decide && majority) begin
                  state_q <= RX_IDLE;
               end else if (bit_end) begin
                  state_q <= RX_DATA;
                  bit_q <= 4'h0;
               end
            end
            RX_DATA: begin
               if (bit_decide) begin
                  if (bit_q < 4'h8) begin
                     shift_q <= {majority, shift_q[7:1]};
                  end else begin
                     par_bit_q <= majority;
                  end
               end
               if (bit_end) begin
                  bit_q <= (bit_q + 4'h1 == data_bits) ? 4'h0 : bit_q + 4'h1;
                  if (bit_q + 4'h1 == data_bits) state_q <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (bit_decide) begin
                  if (!majority) framing_err_flag_q <= 1'b1;
                  if (bit_q + 4'h1 == stop_bits) begin
                     state_q <= RX_IDLE;
                     frame_done_q <= 1'b1;
                     frame_par_q <= parity_enable &&
                        ((^shift_q ^ par_bit_q) != !parity_even);
                  end
               end
               if (bit_end) bit_q <= bit_q + 4'h1;
            end
            default: state_q <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Receive buffer and flags
   // ----------------------------------------------------------------
   wire framing_err_flag_now = framing_err_flag_q;
   wire overrun_ev = frame_done_q && flag_q.full;
   wire load_ev = frame_done_q && !flag_q.full;
   // Clears follow arming; a set in the same cycle wins
   wire clr_full = rd_rxbuf && armed_q.full;
   wire clr_over = rd_rxbuf && armed_q.overrun;
   wire clr_parity_err_flag = rd_rxbuf && armed_q.parity;
   wire clr_framing_err_flag = rd_rxbuf && armed_q.framing;

   always_ff @(posedge clk) begin
      if (srst) begin
         rx_buffer_q <= 8'h00;
         flag_q <= '0;
         armed_q <= '0;
         rx_irq_q <= 1'b0;
      end else begin
         rx_irq_q <= load_ev;
         if (load_ev) begin
            rx_buffer_q <= shift_q;
         end
         flag_q.full <= load_ev | (flag_q.full & !clr_full);
         flag_q.overrun <= overrun_ev | (flag_q.overrun & !clr_over);
         flag_q.parity <= (load_ev & frame_par_q) | (flag_q.parity & !clr_parity_err_flag);
         flag_q.framing <= (load_ev & framing_err_flag_now) | (flag_q.framing & !clr_framing_err_flag);
         if (rd_status) begin
            armed_q <= flag_q;
         end else if (rd_rxbuf) begin
            armed_q <= '0;
         end
      end
   end
   assign rx_irq = rx_irq_q;

   // ----------------------------------------------------------------
   // Transmit side flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_buffer_q <= 8'h00;
         tx_empty_flag_q <= 1'b1;
         tx_done_flag_q <= 1'b1;
         tx_armed_q <= 1'b0;
         tx_pending_q <= 1'b0;
      end else begin
         if (rd_status) tx_armed_q <= 1'b1;
         else if (wr_tx) tx_armed_q <= 1'b0;
         if (wr_tx && tx_armed_q) begin
            tx_buffer_q <= bus.wdata;
            tx_empty_flag_q <= 1'b0;
            tx_pending_q <= 1'b1;
         end
         if (tx_start) begin
            tx_empty_flag_q <= 1'b1;
            tx_done_flag_q <= 1'b0;
            tx_pending_q <= 1'b0;
         end else if (tx_end && !tx_pending_q) begin
            tx_done_flag_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Received character stream
   // ----------------------------------------------------------------
   logic [7:0] fifo_data;
   logic fifo_valid;
   logic [7:0] rx_data_q;
   logic rx_data_valid_q;
   urx_fifo #(.WIDTH(8), .DEPTH(`URX_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .srst(srst),
      .in_data(shift_q),
      .in_valid(load_ev),
      .in_ready(),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(!rx_data_valid_q || rx_data_ready)
   );
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_data_q <= 8'h00;
         rx_data_valid_q <= 1'b0;
      end else if (!rx_data_valid_q || rx_data_ready) begin
         rx_data_q <= fifo_data;
         rx_data_valid_q <= fifo_valid;
      end
   end
   assign rx_data = rx_data_q;
   assign rx_data_valid = rx_data_valid_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_full_on_load;
      @(posedge clk) disable iff (srst) load_ev |=> flag_q.full && rx_buffer_q == $past(shift_q);
   endproperty
   a_full_on_load: assert property (p_full_on_load) else $error("full flag or buffer not loaded");
   property p_overrun_keeps;
      @(posedge clk) disable iff (srst) overrun_ev |=> flag_q.overrun && $stable(rx_buffer_q);
   endproperty
   a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun changed buffer");
   property p_no_start_overrun;
      @(posedge clk) disable iff (srst) (state_q == RX_IDLE && flag_q.overrun) |=> state_q == RX_IDLE;
   endproperty
   a_no_start_overrun: assert property (p_no_start_overrun) else $error("receive during overrun");
   property p_clear_needs_arm;
      @(posedge clk) disable iff (srst) (rd_rxbuf && !armed_q.full && !load_ev && flag_q.full)
         |=> flag_q.full;
   endproperty
   a_clear_needs_arm: assert property (p_clear_needs_arm) else $error("full cleared without status read");
   property p_unarmed_overrun;
      @(posedge clk) disable iff (srst) (rd_rxbuf && flag_q.overrun && !armed_q.overrun) |=> flag_q.overrun;
   endproperty
   a_unarmed_overrun: assert property (p_unarmed_overrun) else $error("late overrun cleared");
   sequence s_irq_once;
      rx_irq ##1 (!rx_irq || load_ev);
   endsequence
   property p_irq_pulse;
      @(posedge clk) disable iff (srst) load_ev |=> s_irq_once;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not pulsed");
   property p_tx_empty;
      @(posedge clk) disable iff (srst) tx_start |=> tx_empty_flag_q && !tx_done_flag_q;
   endproperty
   a_tx_empty: assert property (p_tx_empty) else $error("transmit flags wrong at start");
   property p_arm;
      @(posedge clk) disable iff (srst) rd_status |=> armed_q == $past(flag_q);
   endproperty
   a_arm: assert property (p_arm) else $error("arming wrong");
   property p_en_holds;
      @(posedge clk) disable iff (srst) (state_q != RX_IDLE) |=> $stable(rx_en_active_q);
   endproperty
   a_en_holds: assert property (p_en_holds) else $error("receive enable changed mid-frame");
   property p_parity_set;
      @(posedge clk) disable iff (srst) (load_ev && frame_par_q) |=> flag_q.parity;
   endproperty
   a_parity_set: assert property (p_parity_set) else $error("parity flag not set");
   property p_tx_done_wait;
      @(posedge clk) disable iff (srst) (tx_end && !tx_start && tx_pending_q) |=> $stable(tx_done_flag_q);
   endproperty
   a_tx_done_wait: assert property (p_tx_done_wait) else $error("transmit done set with data pending");
endmodule

// *** verification/tb_urx_receiver.sv ***
// Self-checking bench of the serial receive block
`timescale 1ns/1ps
`include "urx_consts.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("ERROR at %0t: got %h expected %h", $time, a, e); end end
module tb_urx_receiver;
   import urx_pkg::*;
   logic clk;
   logic srst;
   urx_bus_t bus;
   logic [7:0] rdata;
   logic rx_pin;
   logic rt_ext_tick = 1'b0;
   logic tx_start;
   logic tx_end;
   logic rx_irq;
   logic [7:0] rx_data;
   logic rx_data_valid;
   logic rx_data_ready;
   int n_mismatch;
   int num_checks;
   int bit_clks;
   int tick_cnt = 0;
   logic [7:0] ctrl;
   logic [7:0] exp_q[$];

   urx_receiver urx_receiver_i (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .rx_pin(rx_pin),
      .rt_ext_tick(rt_ext_tick), .tx_start(tx_start), .tx_end(tx_end), .rx_irq(rx_irq),
      .rx_data(rx_data), .rx_data_valid(rx_data_valid), .rx_data_ready(rx_data_ready));
   urx_tx_model urx_tx_model_i (.clk(clk), .rx_pin(rx_pin));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // -------------------------------------------
   // External subclock, one tick every fifth clock
   // -------------------------------------------
   always @(posedge clk) begin
      tick_cnt <= (tick_cnt == 4) ? 0 : tick_cnt + 1;
      rt_ext_tick <= (tick_cnt == 4);
   end

   // Sink stalls at random so the FIFO has to hold characters
   always @(posedge clk) begin
      rx_data_ready <= 1'($urandom_range(1, 0));
      if (srst === 1'b0 && rx_data_valid === 1'b1 && rx_data_ready === 1'b1) begin
         if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
         else `CHK(rx_data, exp_q.pop_front())
      end
   end

   // -------------------------------------------
   // Bus and frame tasks
   // -------------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask

   // Watches thirteen bit times, one more than the longest frame, for the load pulse
   task automatic rx_frame(input logic [7:0] d, input bit bad_par, input bit bad_stop, input bit exp_irq);
      bit seen;
      seen = 1'b0;
      if (exp_irq) exp_q.push_back(d);
      fork
         urx_tx_model_i.send(d, bit_clks, ctrl[2], ctrl[3], ctrl[5], bad_par, bad_stop);
         repeat (bit_clks * 13) begin
            @(posedge clk);
            #1;
            if (rx_irq === 1'b1) seen = 1'b1;
         end
      join
      `CHK(seen, exp_irq)
   endtask

   task automatic pulse_tx(input bit which_end);
      @(posedge clk);
      if (which_end) tx_end <= 1'b1;
      else tx_start <= 1'b1;
      @(posedge clk);
      tx_end <= 1'b0;
      tx_start <= 1'b0;
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end

   // -------------------------------------------
   // Main sequence
   // -------------------------------------------
   initial begin
      logic [7:0] a;
      logic [7:0] b;
      srst = 1'b1;
      bus = '0;
      tx_start = 1'b0;
      tx_end = 1'b0;
      n_mismatch = 0;
      num_checks = 0;
      ctrl = 8'h00;
      bit_clks = 208;
      void'($urandom(66843));
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rd_chk(`URX_ADDR_STATUS, 8'h0C);
      // Every rate code, both parity senses, both stop lengths
      for (int r = 0; r < 4; r++) begin
         a = 8'($urandom);
         ctrl = {r[1:0], r[0], 1'b0, r[1], r[0] | r[1], 1'b0, 1'b1};
         bit_clks = (r == 3) ? 80 : 16 * (13 << r);
         wr_reg(`URX_ADDR_CTRL, ctrl);
         rx_frame(a, 1'b0, 1'b0, 1'b1);
         rd_chk(`URX_ADDR_STATUS, 8'h1C);
         rd_chk(`URX_ADDR_RXBUF, a);
         rd_chk(`URX_ADDR_STATUS, 8'h0C);
      end
      ctrl = 8'h0D;
      bit_clks = 208;
      wr_reg(`URX_ADDR_CTRL, ctrl);
      for (int k = 0; k < 3; k++) begin
         a = 8'($urandom);
         rx_frame(a, k == 0, k == 1, 1'b1);
         rd_chk(`URX_ADDR_STATUS, k == 0 ? 8'h9C : (k == 1 ? 8'h5C : 8'h1C));
         rd_chk(`URX_ADDR_RXBUF, a);
         rd_chk(`URX_ADDR_STATUS, 8'h0C);
      end
      // Overrun arriving between status read and buffer read
      a = 8'($urandom);
      b = 8'($urandom);
      rx_frame(a, 1'b0, 1'b0, 1'b1);
      rd_chk(`URX_ADDR_STATUS, 8'h1C);
      rx_frame(b, 1'b0, 1'b0, 1'b0);
      rd_chk(`URX_ADDR_RXBUF, a);
      rd_chk(`URX_ADDR_STATUS, 8'h2C);
      rx_frame(b, 1'b0, 1'b0, 1'b0);
      rd_chk(`URX_ADDR_RXBUF, a);
      rd_chk(`URX_ADDR_STATUS, 8'h0C);
      // Disable in mid-frame lets that frame finish, then stops reception
      fork
         rx_frame(a, 1'b0, 1'b0, 1'b1);
         begin
            repeat (bit_clks * 3) @(posedge clk);
            wr_reg(`URX_ADDR_CTRL, ctrl & 8'hFE);
         end
      join
      rx_frame(b, 1'b0, 1'b0, 1'b0);
      rd_chk(`URX_ADDR_STATUS, 8'h1C);
      rd_chk(`URX_ADDR_RXBUF, a);
      rd_chk(4'hF, 8'h00);
      // Transmit flags; the status read above arms one write, a second write is ignored
      b = 8'($urandom);
      wr_reg(`URX_ADDR_TXBUF, b);
      pulse_tx(1'b0);
      wr_reg(`URX_ADDR_TXBUF, ~b);
      rd_chk(`URX_ADDR_TXBUF, b);
      rd_chk(`URX_ADDR_STATUS, 8'h04);
      a = 8'($urandom);
      wr_reg(`URX_ADDR_TXBUF, a);
      rd_chk(`URX_ADDR_TXBUF, a);
      pulse_tx(1'b1);
      rd_chk(`URX_ADDR_STATUS, 8'h00);
      pulse_tx(1'b0);
      rd_chk(`URX_ADDR_STATUS, 8'h04);
      pulse_tx(1'b1);
      rd_chk(`URX_ADDR_STATUS, 8'h0C);
      repeat (20) @(posedge clk);
      `CHK(exp_q.size(), 0)
      give_verdict();
   end
endmodule

// *** verification/urx_tx_model.sv ***
// Remote asynchronous transmitter that drives the receive line
`timescale 1ns/1ps
module urx_tx_model (
   input wire logic clk,
   output logic rx_pin
);
   // Line idles at the mark level between frames
   initial rx_pin = 1'b1;

   // -------------------------------------------
   // Frame sender; bad_par and bad_stop break one field on purpose
   // -------------------------------------------
   task automatic send(input logic [7:0] d, input int bit_clks, input bit par_en, input bit even,
      input bit two_stop, input bit bad_par, input bit bad_stop);
      logic q[$];
      q = {1'b0};
      for (int i = 0; i < 8; i++) begin
         q.push_back(d[i]);
      end
      if (par_en) begin
         q.push_back((even ? ^d : ~^d) ^ bad_par);
      end
      q.push_back(~bad_stop);
      if (two_stop) begin
         q.push_back(1'b1);
      end
      // Start each frame on a clock edge
      @(posedge clk);
      foreach (q[i]) begin
         rx_pin <= q[i];
         repeat (bit_clks) @(posedge clk);
      end
      rx_pin <= 1'b1;
   endtask
endmodule
